// ===== bench/cad_mem_model.sv
// Behavioural byte memory that answers the core's fetch and data cycles
`timescale 1ns/10ps
module cad_mem_model
(
	input wire logic sys_clk_in,
	input wire logic ce_in,
	input wire logic [15:0] addr_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h5A;
	// Between reads the line shows the inverse of the last byte, so a core
	// that samples outside its read cycle cannot get a lucky match
	assign rdata_out = rd_in ? mem[addr_in] : ~last;
	// Writes land on the edge ending the strobe cycle, only while enabled
	always @(posedge sys_clk_in)
	begin
		if (rd_in)
			last <= mem[addr_in];
		if (wr_in && ce_in)
			mem[addr_in] <= wdata_in;
	end
endmodule

// ===== bench/tb_top.sv
// Register-level testbench that runs two short programs through the core
`timescale 1ns/10ps
module tb_top
	import cad_pkg::*;
;
	logic sys_clk_in, rst_in, ce_in;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata, rd_val;
	logic [1:0] bresp, rresp, rd_resp;
	logic [15:0] mem_addr;
	logic mem_rd, mem_wr;
	logic [7:0] mem_wdata, mem_rdata;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;

	cad_core cad_core_i (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hF),
		.s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready),
		.mem_addr_out(mem_addr),
		.mem_rd_out(mem_rd),
		.mem_wr_out(mem_wr),
		.mem_wdata_out(mem_wdata),
		.mem_rdata_in(mem_rdata)
	);

	cad_mem_model cad_mem_model_i (
		.sys_clk_in(sys_clk_in),
		.ce_in(ce_in),
		.addr_in(mem_addr),
		.rd_in(mem_rd),
		.wr_in(mem_wr),
		.wdata_in(mem_wdata),
		.rdata_out(mem_rdata)
	);

	// Free-running 100 MHz clock
	initial
	begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	task automatic give_verdict;
		$display("Checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// A hung handshake or a core that never halts ends the run here
	always @(posedge sys_clk_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Readies are sampled at the falling edge, where they have settled,
	// and count as taken at the following rising edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta, tw, v;
		logic [1:0] rs;
		@(posedge sys_clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		v = 1'b0;
		while (!v)
		begin
			@(negedge sys_clk_in);
			ta = awvalid && awready;
			tw = wvalid && wready;
			v = bvalid;
			rs = bresp;
			@(posedge sys_clk_in);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk("bresp", {30'h0, rs}, {30'h0, er});
	endtask

	task automatic axi_rd(input logic [7:0] a);
		logic r, v;
		@(posedge sys_clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		v = 1'b0;
		while (!v)
		begin
			@(negedge sys_clk_in);
			r = arvalid && arready;
			v = rvalid;
			rd_val = rdata;
			rd_resp = rresp;
			@(posedge sys_clk_in);
			if (r)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		axi_rd(a);
		chk(nm, rd_val, e);
	endtask

	task automatic load(input logic [15:0] a, input logic [255:0] v,
		input int n);
		for (int i = 0; i < n; i++)
			cad_mem_model_i.mem[a + 16'(i)] = v[8 * (n - 1 - i) +: 8];
	endtask

	task automatic mem_chk(input logic [15:0] a, input logic [7:0] e);
		chk("mem", {24'h0, cad_mem_model_i.mem[a]}, {24'h0, e});
	endtask

	// Start at a program address, then poll until the core halts
	task automatic run_prog(input logic [15:0] pc);
		axi_wr(REG_START, {16'h0, pc}, RESP_OKAY);
		axi_wr(REG_CTRL, 32'h3, RESP_OKAY);
		// Freeze mid-program; results must match an unbroken run
		repeat (3) @(posedge sys_clk_in);
		ce_in <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		ce_in <= 1'b1;
		do
			axi_rd(REG_CTRL);
		while (rd_val[0] !== 1'b0);
		chk("ctrl", rd_val, 32'h2);
	endtask

	// Main sequence: register map first, then both programs
	initial
	begin
		rst_in = 1'b1;
		ce_in = 1'b1;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		// Arithmetic, branches and adjusts; halts on opcode 00
		load(16'h0100,
			256'hAB7FA901482402A941BB40C41234A7FEAF81EB05472402484800, 26);
		// Every shift opcode, register and memory forms
		load(16'h0200, 256'h3850375168CF67D0585778779E68539E6753474800, 21);
		cad_mem_model_i.mem[16'h0040] = 8'h3E;
		cad_mem_model_i.mem[16'h1234] = 8'hF0;
		// Trap: reversed operand bytes would fetch this instead
		cad_mem_model_i.mem[16'h3412] = 8'h0F;
		cad_mem_model_i.mem[16'hFF86] = 8'h02;
		cad_mem_model_i.mem[16'h0050] = 8'h81;
		cad_mem_model_i.mem[16'h0051] = 8'h81;
		cad_mem_model_i.mem[16'hFF01] = 8'h40;
		cad_mem_model_i.mem[16'h0150] = 8'h11;
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		rd_chk(REG_FLAGS, 32'h0, "flags");
		rd_chk(REG_PCSP, 32'h00FF0000, "pcsp");
		axi_wr(REG_FLAGS, 32'hFF, RESP_OKAY);
		rd_chk(REG_FLAGS, 32'hFF, "flags");
		axi_wr(REG_FLAGS, 32'h08, RESP_OKAY);
		rd_chk(REG_FLAGS, 32'h08, "flags");
		axi_wr(8'h14, 32'h1, RESP_SLVERR);
		axi_rd(8'h14);
		chk("rresp", {30'h0, rd_resp}, {30'h0, RESP_SLVERR});
		chk("rdata", rd_val, 32'h0);
		axi_wr(REG_ACCIDX, 32'hFFFFFFFF, RESP_OKAY);
		rd_chk(REG_ACCIDX, 32'h0, "accidx");
		run_prog(16'h0100);
		rd_chk(REG_FLAGS, 32'h8C, "flags");
		rd_chk(REG_ACCIDX, 32'h00FF81C1, "accidx");
		axi_rd(REG_PCSP);
		chk("sp", {16'h0, rd_val[31:16]}, 32'h00FD);
		run_prog(16'h0200);
		rd_chk(REG_FLAGS, 32'h0D, "flags");
		rd_chk(REG_ACCIDX, 32'h00FF01C0, "accidx");
		mem_chk(16'h0050, 8'h04);
		mem_chk(16'h0051, 8'hE0);
		mem_chk(16'hFF01, 8'hC0);
		mem_chk(16'h0150, 8'h11);
		give_verdict();
	end
endmodule

// ===== hw/cad_core.sv
// Arithmetic decode and execute core with AXI4-Lite register access
//
// Overview of operation
// - Flags byte: V bit7, H bit4, I bit3, N bit2, Z bit1, C bit0.
// - Carry is carry out of bit 7; borrow for subtraction.
// - 16-bit memory values: high byte at lower address, low next.
// - Zero-page address is operand byte with high byte forced zero.
// - Branch target is next address plus sign-extended 8-bit offset.
// - Post-increment indexed modes exist only for compare-branch and copy.
// - Indexed address is index pair plus none, 8-bit or 16-bit offset.
// - Stack-relative address is stack pointer plus 8 or 16-bit offset.
// - Two-byte operands follow the opcode high byte first.
// - Long-address operand is a full 64-Kbyte address.
// - Add with carry: A+M+C, updates V H N Z C, keeps I.
// - Add: A+M without carry, updates V H N Z C, keeps I.
// - Stack and index adjust add sign-extended byte, no flag change.
// - AND: A&M, clears V, updates N Z, keeps H I C.
// - Left shift opcodes 38,48,58,68,78,9E68; updates V N Z C.
// - Right shift opcodes 37,47,57,67,77,9E67; updates V N Z C.
// - Branch on carry clear, opcode 24, no flag change, 3 cycles.
`timescale 1ns/10ps
module cad_core
	import cad_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [15:0] mem_addr_out,
	output logic mem_rd_out,
	output logic mem_wr_out,
	output logic [7:0] mem_wdata_out,
	input wire logic [7:0] mem_rdata_in
);
	typedef struct packed {
		cad_state_e st;
		logic pre;
		logic [7:0] op;
		logic [7:0] b1;
		logic [15:0] ea;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] hx;
		logic [7:0] acc;
		logic [7:0] flags;
		logic [15:0] mem_addr;
		logic mem_rd;
		logic mem_wr;
		logic [7:0] mem_wdata;
		logic run;
		logic illegal;
		logic [15:0] start_pc;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cad_state_s;

	cad_state_s s;
	cad_state_s n;
	cad_dec_s dec;
	logic [15:0] res;
	logic [7:0] opnd;
	logic [7:0] op_src;

	// Opcode to class and operand mode; unknown codes fall to illegal
	function automatic cad_dec_s decode(input logic pre,
		input logic [7:0] op);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = op[7:4];
		lo = op[3:0];
		decode.cls = illegal_op;
		decode.mode = no_operand_mode;
		if (!pre && op == OP_SP_ADJ)
		begin
			decode.cls = stack_adjust_op;
			decode.mode = literal_operand_mode;
		end
		else if (!pre && op == OP_HX_ADJ)
		begin
			decode.cls = index_adjust_op;
			decode.mode = literal_operand_mode;
		end
		else if (!pre && op == OP_BR_CC)
		begin
			decode.cls = branch_carry_clear_op;
			decode.mode = relative_mode;
		end
		else if (lo == LO_ADC || lo == LO_ADD || lo == LO_AND)
		begin
			decode.cls = (lo == LO_ADC) ? adc_op :
				((lo == LO_ADD) ? add_op : and_op);
			if (!pre)
			begin
				case (hi)
					HI_LIT: decode.mode = literal_operand_mode;
					HI_DIR: decode.mode = zero_page_mode;
					HI_LONG: decode.mode = long_address_mode;
					HI_HX16: decode.mode = index_long_offset_mode;
					HI_HX8: decode.mode = index_short_offset_mode;
					HI_HX: decode.mode = index_plain_mode;
					default: decode.cls = illegal_op;
				endcase
			end
			else if (hi == HI_HX16)
				decode.mode = stack_long_offset_mode;
			else if (hi == HI_HX8)
				decode.mode = stack_short_offset_mode;
			else
				decode.cls = illegal_op;
		end
		else if (lo == LO_SHL || lo == LO_SHR)
		begin
			decode.cls = (lo == LO_SHL) ? shift_left_op :
				shift_right_signed_op;
			if (!pre)
			begin
				case (hi)
					SH_DIR: decode.mode = zero_page_mode;
					SH_A: decode.mode = no_operand_mode;
					SH_X: decode.mode = no_operand_x_mode;
					SH_HX8: decode.mode = index_short_offset_mode;
					SH_HX: decode.mode = index_plain_mode;
					default: decode.cls = illegal_op;
				endcase
			end
			else if (hi == SH_HX8)
				decode.mode = stack_short_offset_mode;
			else
				decode.cls = illegal_op;
		end
		// Post-increment modes are never decoded here
	endfunction

	// Result and new flags; H and I pass through unless the class sets them
	function automatic logic [15:0] alu(input cad_cls_e cls,
		input logic [7:0] a, input logic [7:0] m, input logic [7:0] f);
		logic [8:0] sum;
		logic [4:0] half;
		logic [7:0] r;
		logic [7:0] g;
		logic cin;
		cin = (cls == adc_op) ? f[FLG_C] : 1'b0;
		sum = {1'b0, a} + {1'b0, m} + {8'h00, cin};
		half = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
		g = f;
		r = a;
		case (cls)
			adc_op, add_op:
			begin
				r = sum[7:0];
				g[FLG_H] = half[4];
				g[FLG_V] = (a[7] == m[7]) && (r[7] != a[7]);
				g[FLG_C] = sum[8];
			end
			and_op:
			begin
				r = a & m;
				g[FLG_V] = 1'b0;
			end
			shift_left_op:
			begin
				r = {m[6:0], 1'b0};
				g[FLG_C] = m[7];
			end
			shift_right_signed_op:
			begin
				r = {m[7], m[7:1]};
				g[FLG_C] = m[0];
			end
			default: r = a;
		endcase
		if (cls == shift_left_op || cls == shift_right_signed_op)
			g[FLG_V] = r[7] ^ g[FLG_C];
		if (cls != illegal_op)
		begin
			g[FLG_N] = r[7];
			g[FLG_Z] = (r == 8'h00);
		end
		alu = {g, r};
	endfunction

	// Handshakes are combinational from held state
	assign s_axi_awready_out = !s.aw_held && !s.bvalid;
	assign s_axi_wready_out = !s.w_held && !s.bvalid;
	assign s_axi_arready_out = !s.rvalid;
	assign s_axi_bvalid_out = s.bvalid;
	assign s_axi_bresp_out = s.bresp;
	assign s_axi_rvalid_out = s.rvalid;
	assign s_axi_rdata_out = s.rdata;
	assign s_axi_rresp_out = s.rresp;
	assign mem_addr_out = s.mem_addr;
	assign mem_rd_out = s.mem_rd;
	assign mem_wr_out = s.mem_wr;
	assign mem_wdata_out = s.mem_wdata;

	// Operand source: register for inherent shifts, else the data bus
	assign op_src = (s.st == S_DECODE) ? mem_rdata_in : s.op;
	assign dec = decode(s.pre, op_src);
	assign opnd = (dec.mode == no_operand_x_mode) ? s.hx[7:0] :
		((dec.mode == no_operand_mode) ? s.acc : mem_rdata_in);
	assign res = alu(dec.cls, s.acc, opnd, s.flags);

	// Bus slave first, core second, so core flag and halt updates win
	always_comb
	begin
		n = s;
		n.mem_rd = 1'b0;
		n.mem_wr = 1'b0;
		if (s_axi_awvalid_in && s_axi_awready_out)
		begin
			n.aw_held = 1'b1;
			n.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out)
		begin
			n.w_held = 1'b1;
			n.w_data = s_axi_wdata_in;
			n.w_strb = s_axi_wstrb_in;
		end
		if (s.aw_held && s.w_held)
		begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			case ({s.aw_addr[7:2], 2'b00})
				REG_FLAGS: if (s.w_strb[0]) n.flags = s.w_data[7:0];
				REG_CTRL:
				begin
					if (s.w_strb[0])
					begin
						n.run = s.w_data[CTRL_RUN];
						if (s.w_data[CTRL_ILL])
							n.illegal = 1'b0;
					end
				end
				REG_START:
				begin
					if (s.w_strb[0]) n.start_pc[7:0] = s.w_data[7:0];
					if (s.w_strb[1]) n.start_pc[15:8] = s.w_data[15:8];
				end
				REG_ACCIDX, REG_PCSP: n.bresp = RESP_OKAY;
				default: n.bresp = RESP_SLVERR;
			endcase
		end
		if (s.bvalid && s_axi_bready_in)
			n.bvalid = 1'b0;
		if (s.rvalid && s_axi_rready_in)
			n.rvalid = 1'b0;
		if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = 32'h0000_0000;
			case ({s_axi_araddr_in[7:2], 2'b00})
				REG_FLAGS: n.rdata[7:0] = s.flags;
				REG_CTRL: n.rdata[CTRL_ILL:CTRL_RUN] = {s.illegal, s.run};
				REG_START: n.rdata[15:0] = s.start_pc;
				REG_ACCIDX: n.rdata[23:0] = {s.hx, s.acc};
				REG_PCSP: n.rdata = {s.sp, s.pc};
				default: n.rresp = RESP_SLVERR;
			endcase
		end
		// Instruction sequencer; requests on pins one cycle after set
		case (s.st)
			S_IDLE:
			begin
				n.pre = 1'b0;
				if (s.run)
				begin
					n.pc = s.start_pc;
					n.st = S_FETCH;
				end
			end
			S_FETCH:
			begin
				if (!s.run && !s.pre)
					n.st = S_IDLE;
				else
				begin
					n.mem_addr = s.pc;
					n.mem_rd = 1'b1;
					n.pc = s.pc + PC_STEP;
					n.st = S_DECODE;
				end
			end
			S_DECODE:
			begin
				n.op = mem_rdata_in;
				n.st = S_FETCH;
				if (!s.pre && mem_rdata_in == OP_PREFIX)
					n.pre = 1'b1;
				else if (dec.cls == illegal_op)
				begin
					n.run = 1'b0;
					n.illegal = 1'b1;
					n.st = S_IDLE;
				end
				else if (dec.mode == no_operand_mode)
				begin
					{n.flags, n.acc} = res;
					n.pre = 1'b0;
				end
				else if (dec.mode == no_operand_x_mode)
				begin
					{n.flags, n.hx[7:0]} = res;
					n.pre = 1'b0;
				end
				else if (dec.mode == index_plain_mode)
				begin
					n.ea = s.hx;
					n.mem_addr = s.hx;
					n.mem_rd = 1'b1;
					n.st = S_EXEC;
				end
				else
				begin
					n.mem_addr = s.pc;
					n.mem_rd = 1'b1;
					n.pc = s.pc + PC_STEP;
					n.st = S_BYTE1;
				end
			end
			S_BYTE1:
			begin
				n.b1 = mem_rdata_in;
				n.mem_rd = 1'b1;
				n.st = S_EXEC;
				case (dec.mode)
					literal_operand_mode:
					begin
						n.mem_rd = 1'b0;
						n.st = S_FETCH;
						n.pre = 1'b0;
						if (dec.cls == stack_adjust_op)
							n.sp = s.sp + {{8{mem_rdata_in[7]}}, mem_rdata_in};
						else if (dec.cls == index_adjust_op)
							n.hx = s.hx + {{8{mem_rdata_in[7]}}, mem_rdata_in};
						else
							{n.flags, n.acc} = res;
					end
					relative_mode:
					begin
						n.mem_rd = 1'b0;
						n.st = S_FETCH;
						n.pre = 1'b0;
						if (!s.flags[FLG_C])
							n.pc = s.pc + {{8{mem_rdata_in[7]}}, mem_rdata_in};
					end
					zero_page_mode: n.ea = {ZERO_PAGE, mem_rdata_in};
					index_short_offset_mode:
						n.ea = s.hx + {8'h00, mem_rdata_in};
					stack_short_offset_mode:
						n.ea = s.sp + {8'h00, mem_rdata_in};
					default:
					begin
						n.ea = s.pc;
						n.pc = s.pc + PC_STEP;
						n.st = S_BYTE2;
					end
				endcase
				n.mem_addr = n.ea;
			end
			S_BYTE2:
			begin
				// High byte came first, low byte is on the bus now
				n.ea = {s.b1, mem_rdata_in};
				if (dec.mode == index_long_offset_mode)
					n.ea = s.hx + {s.b1, mem_rdata_in};
				else if (dec.mode == stack_long_offset_mode)
					n.ea = s.sp + {s.b1, mem_rdata_in};
				n.mem_addr = n.ea;
				n.mem_rd = 1'b1;
				n.st = S_EXEC;
			end
			S_EXEC:
			begin
				n.flags = res[15:8];
				n.pre = 1'b0;
				n.st = S_FETCH;
				if (dec.cls == shift_left_op || dec.cls == shift_right_signed_op)
				begin
					n.mem_addr = s.ea; // Read-modify-write in place
					n.mem_wr = 1'b1;
					n.mem_wdata = res[7:0];
				end
				else
					n.acc = res[7:0];
			end
			default: n.st = S_IDLE;
		endcase
	end

	// Clock enable freezes every bit, bus slave included
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s <= '0;
			s.st <= S_IDLE;
			s.sp <= SP_RST;
			s.flags <= FLAGS_RST;
		end
		else if (ce_in)
			s <= n;
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	sequence seq_brcc_dec;
		ce_in && s.st == S_DECODE && !s.pre && mem_rdata_in == OP_BR_CC;
	endsequence
	// First operand cycle; combined with conditions by sequence and
	sequence seq_byte1;
		ce_in && s.st == S_BYTE1;
	endsequence
	AST_BRCC_CYCLES: assert property (seq_brcc_dec ##1 seq_byte1 |=>
		s.st == S_FETCH && s.flags == $past(s.flags, 2))
		else $error("branch on carry clear took wrong cycles or flags");
	AST_BRCC_TARGET: assert property (seq_byte1 and
		dec.cls == branch_carry_clear_op |=> s.pc == ($past(s.flags[FLG_C]) ?
		$past(s.pc) : $past(s.pc) + {{8{$past(mem_rdata_in[7])}},
		$past(mem_rdata_in)})) else $error("branch target wrong");
	AST_ZP_ADDR: assert property (seq_byte1 and
		dec.mode == zero_page_mode |=> mem_rd_out &&
		mem_addr_out == {ZERO_PAGE, $past(mem_rdata_in)})
		else $error("zero page address not forced");
	AST_LONG_ORDER: assert property (ce_in && s.st == S_BYTE2 &&
		dec.mode == long_address_mode |=> mem_addr_out ==
		{$past(s.b1), $past(mem_rdata_in)}) else $error("long address order");
	AST_ADD_IMASK: assert property (ce_in && s.st == S_EXEC &&
		(dec.cls == adc_op || dec.cls == add_op) |=>
		$stable(s.flags[FLG_I])) else $error("add changed interrupt mask");
	AST_AND_FLAGS: assert property (ce_in && s.st == S_EXEC &&
		dec.cls == and_op |=> !s.flags[FLG_V] && $stable(s.flags[FLG_C])
		&& s.flags[FLG_Z] == (s.acc == 8'h00)) else $error("and flags");
	AST_ADJ_NOFLAG: assert property (seq_byte1 and
		dec.cls == stack_adjust_op |=> $stable(s.flags) &&
		s.sp == $past(s.sp) + {{8{$past(mem_rdata_in[7])}},
		$past(mem_rdata_in)}) else $error("stack adjust wrong");
	AST_SHIFT_V: assert property (ce_in && s.st == S_DECODE &&
		(dec.cls == shift_left_op || dec.cls == shift_right_signed_op) &&
		dec.mode == no_operand_mode |=> s.flags[FLG_V] ==
		(s.flags[FLG_N] ^ s.flags[FLG_C])) else $error("shift overflow");
	AST_CARRY_OUT: assert property (ce_in && s.st == S_EXEC &&
		dec.cls == add_op |=> s.flags[FLG_C] == ({1'b0, $past(s.acc)} +
		{1'b0, $past(mem_rdata_in)} > 9'h0FF)) else $error("carry out");
endmodule

// ===== hw/cad_pkg.sv
// Constants, opcodes and types shared by the arithmetic decode core
package cad_pkg;
	localparam logic [7:0] OP_PREFIX = 8'h9E;
	localparam logic [7:0] OP_SP_ADJ = 8'hA7;
	localparam logic [7:0] OP_HX_ADJ = 8'hAF;
	localparam logic [7:0] OP_BR_CC = 8'h24;
	localparam logic [3:0] LO_ADC = 4'h9;
	localparam logic [3:0] LO_ADD = 4'hB;
	localparam logic [3:0] LO_AND = 4'h4;
	localparam logic [3:0] LO_SHL = 4'h8;
	localparam logic [3:0] LO_SHR = 4'h7;
	localparam logic [3:0] HI_LIT = 4'hA;
	localparam logic [3:0] HI_DIR = 4'hB;
	localparam logic [3:0] HI_LONG = 4'hC;
	localparam logic [3:0] HI_HX16 = 4'hD;
	localparam logic [3:0] HI_HX8 = 4'hE;
	localparam logic [3:0] HI_HX = 4'hF;
	localparam logic [3:0] SH_DIR = 4'h3;
	localparam logic [3:0] SH_A = 4'h4;
	localparam logic [3:0] SH_X = 4'h5;
	localparam logic [3:0] SH_HX8 = 4'h6;
	localparam logic [3:0] SH_HX = 4'h7;
	localparam int FLG_V = 7;
	localparam int FLG_H = 4;
	localparam int FLG_I = 3;
	localparam int FLG_N = 2;
	localparam int FLG_Z = 1;
	localparam int FLG_C = 0;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_ILL = 1;
	localparam logic [7:0] ZERO_PAGE = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [15:0] SP_RST = 16'h00FF;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam logic [7:0] REG_FLAGS = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_START = 8'h08;
	localparam logic [7:0] REG_ACCIDX = 8'h0C;
	localparam logic [7:0] REG_PCSP = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {S_IDLE = 3'b000, S_FETCH = 3'b001,
		S_DECODE = 3'b010, S_BYTE1 = 3'b011, S_BYTE2 = 3'b100,
		S_EXEC = 3'b101} cad_state_e;
	// shift_left_op also serves as logical_left_shift_op
	typedef enum logic [3:0] {illegal_op = 4'h0, adc_op = 4'h1,
		add_op = 4'h2, and_op = 4'h3, shift_left_op = 4'h4,
		shift_right_signed_op = 4'h5, branch_carry_clear_op = 4'h6,
		stack_adjust_op = 4'h7, index_adjust_op = 4'h8} cad_cls_e;
	typedef enum logic [3:0] {no_operand_mode = 4'h0,
		no_operand_x_mode = 4'h1, literal_operand_mode = 4'h2,
		zero_page_mode = 4'h3, long_address_mode = 4'h4,
		index_plain_mode = 4'h5, index_short_offset_mode = 4'h6,
		index_long_offset_mode = 4'h7, stack_short_offset_mode = 4'h8,
		stack_long_offset_mode = 4'h9, relative_mode = 4'hA} cad_mode_e;
	typedef struct packed {
		cad_cls_e cls;
		cad_mode_e mode;
	} cad_dec_s;
endpackage
